/* File: inc/tsof_defines.vh */
`ifndef TSOF_DEFINES_VH
`define TSOF_DEFINES_VH
// per-stream register block: stream index in addr[5:4]
`define TSOF_OFS_CTRL      2'h0
`define TSOF_OFS_PORT      2'h1
`define TSOF_OFS_ADDR      2'h2
`define TSOF_OFS_RATE      2'h3
`define TSOF_OFS_STATUS    8'h40
`define TSOF_OFS_DROPS     8'h44
// control word fields
`define TSOF_CTRL_EN       0
`define TSOF_CTRL_RTP      1
`define TSOF_CTRL_FEC      2
`define TSOF_CTRL_PAD_LO   3
`define TSOF_CTRL_PAD_HI   4
`define TSOF_CTRL_CONN     5
`define TSOF_PAD_OFF       2'h0
`define TSOF_PAD_AUTO      2'h1
`define TSOF_PAD_MAN       2'h2
// reset values
`define TSOF_RST_CTRL      6'h00
`define TSOF_RST_PORT      16'h0400
`define TSOF_RST_ADDR      32'hE101_0101
`define TSOF_RST_RATE      32'h0000_0800
// packet framing
`define TSOF_PKT_LAST      8'hBB
`define TSOF_SLOT_LAST     3'h6
`define TSOF_CRED_NEED     4'h7
`define TSOF_RTP_LAST      8'h0B
`define TSOF_SYNC          8'h47
`define TSOF_NULL_PID      13'h1FFF
`define TSOF_NULL_B3       8'h10
`define TSOF_FILL          8'hFF
`define TSOF_RTP_B0        8'h80
`define TSOF_RTP_PT        8'h21
`define TSOF_LOOP_NET      8'h7F
`define TSOF_BCAST_IP      32'hFFFF_FFFF
`define TSOF_RESP_OK       2'h0
`define TSOF_RESP_ERR      2'h2
`endif

/* File: rtl/tsof_framer.v */
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "tsof_defines.vh"
module tsof_framer #(
    parameter NUM_STREAMS = 4,              // streams on this port
    parameter [31:0] SSRC = 32'h5A5A_0001,  // arbitrary value
    parameter [31:0] AUTO_INIT = 32'h0000_2000 // auto period start
) (
    input  wire        core_clk_i,      // clock, 25 MHz
    input  wire        arst_n_i,        // async reset, low
    input  wire [7:0]  s_axi_awaddr_i,  // write address
    input  wire        s_axi_awvalid_i, // write address valid
    output wire        s_axi_awready_o, // write address ready
    input  wire [31:0] s_axi_wdata_i,   // write data
    input  wire [3:0]  s_axi_wstrb_i,   // byte enables
    input  wire        s_axi_wvalid_i,  // write data valid
    output wire        s_axi_wready_o,  // write data ready
    output wire [1:0]  s_axi_bresp_o,   // write response
    output wire        s_axi_bvalid_o,  // write response valid
    input  wire        s_axi_bready_i,  // write response ready
    input  wire [7:0]  s_axi_araddr_i,  // read address
    input  wire        s_axi_arvalid_i, // read address valid
    output wire        s_axi_arready_o, // read address ready
    output wire [31:0] s_axi_rdata_o,   // read data
    output wire [1:0]  s_axi_rresp_o,   // read response
    output wire        s_axi_rvalid_o,  // read valid
    input  wire        s_axi_rready_i,  // read ready
    input  wire [3:0]  src_avail_i,     // packet waiting per stream
    input  wire [3:0]  src_cfg_chg_i,   // source reconfigured pulse
    output wire [1:0]  src_sel_o,       // stream being served
    input  wire [7:0]  src_data_i,      // source byte
    input  wire        src_valid_i,     // source byte valid
    output wire        src_ready_o,     // source byte taken
    output wire        dg_start_o,      // datagram start pulse
    output wire [1:0]  dg_stream_o,     // datagram stream
    output wire [15:0] dg_port_o,       // udp destination port
    output wire [31:0] dg_addr_o,       // ip destination
    output wire        dg_bcast_o,      // use broadcast mac
    output wire        dg_rtp_o,        // rtp header present
    output wire        dg_fec_o,        // fec on for stream
    output wire [7:0]  out_data_o,      // payload byte
    output wire        out_valid_o,     // payload byte valid
    output wire        out_sop_o,       // first payload byte
    output wire        out_eop_o,       // last payload byte
    input  wire        out_ready_i      // downstream ready
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_HDR  = 6'h02;
    localparam [5:0] ST_SLOT = 6'h04;
    localparam [5:0] ST_SRC  = 6'h08;
    localparam [5:0] ST_NUL  = 6'h10;
    localparam [5:0] ST_DROP = 6'h20;

    // ======================================================
    // register storage
    // ======================================================
    // four stream slots
    reg  [5:0]  ctrl_q [0:NUM_STREAMS-1];
    reg  [15:0] port_q [0:NUM_STREAMS-1];
    reg  [31:0] addr_q [0:NUM_STREAMS-1];
    reg  [31:0] rate_q [0:NUM_STREAMS-1];
    reg  [31:0] per_q  [0:NUM_STREAMS-1];
    reg  [31:0] gap_q  [0:NUM_STREAMS-1];
    reg  [31:0] tmr_q  [0:NUM_STREAMS-1];
    reg  [3:0]  cred_q [0:NUM_STREAMS-1];
    reg  [15:0] seq_q  [0:NUM_STREAMS-1];
    reg  [3:0]  rej_q;
    reg  [3:0]  avail_d_q;
    reg  [31:0] drops_q;
    reg  [31:0] ts_q;

    reg         aw_got_q;
    reg  [7:0]  awaddr_q;
    reg         w_got_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         bvalid_q;
    reg  [1:0]  bresp_q;
    reg         rvalid_q;
    reg  [31:0] rdata_q;
    reg  [1:0]  rresp_q;

    reg  [5:0]  st_q;
    reg  [1:0]  cur_q;
    reg  [1:0]  rr_q;
    reg  [2:0]  slot_q;
    reg  [7:0]  bc_q;
    reg         first_q;
    reg  [31:0] stamp_q;
    reg         dg_start_q;
    reg  [15:0] dg_port_q;
    reg  [31:0] dg_addr_q;
    reg         dg_rtp_q;
    reg         dg_fec_q;
    reg  [7:0]  out_data_q;
    reg         out_valid_q;
    reg         out_sop_q;
    reg         out_eop_q;

    function rtp_eff;
        input [5:0] c;
        rtp_eff = c[`TSOF_CTRL_RTP] | c[`TSOF_CTRL_FEC];
    endfunction

    // with rtp, round odd port up to even, 0xFFFF down to 0xFFFE
    function [15:0] port_eff;
        input [15:0] p;
        input        rtp;
        if (rtp && p[0])
            port_eff = (p == 16'hFFFF) ? 16'hFFFE : p + 16'h0001;
        else
            port_eff = p;
    endfunction

    wire [3:0] fec_vec;
    genvar g;
    generate
        for (g = 0; g < NUM_STREAMS; g = g + 1) begin : g_fec
            assign fec_vec[g] = ctrl_q[g][`TSOF_CTRL_FEC];
        end
    endgenerate

    // bit 32 flags a mapped address
    function [32:0] reg_word;
        input [7:0] a;
        reg [1:0] s;
        begin
            s = a[5:4];
            reg_word = 33'h0_0000_0000;
            if (a[7:6] == 2'b00 && a[1:0] == 2'b00) begin
                case (a[3:2])
                    `TSOF_OFS_CTRL: reg_word = {7'h40, 20'h0_0000,
                                                ctrl_q[s]};
                    `TSOF_OFS_PORT: reg_word = {17'h1_0000,
                        port_eff(port_q[s], rtp_eff(ctrl_q[s]))};
                    `TSOF_OFS_ADDR: reg_word = {1'b1, addr_q[s]};
                    default:        reg_word = {1'b1, rate_q[s]};
                endcase
            end else if (a == `TSOF_OFS_STATUS) begin
                reg_word = {25'h100_0000, fec_vec, rej_q};
            end else if (a == `TSOF_OFS_DROPS) begin
                reg_word = {1'b1, drops_q};
            end
        end
    endfunction

    // ======================================================
    // axi4-lite slave
    // ======================================================
    wire        do_wr = aw_got_q & w_got_q & ~bvalid_q;
    wire [32:0] wr_old = reg_word(awaddr_q);
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [31:0] wval = (wr_old[31:0] & ~wmask) | (wdata_q & wmask);
    wire [1:0]  wsel = awaddr_q[5:4];
    wire        wstr = do_wr & wr_old[32] & (awaddr_q[7:6] == 2'b00);
    wire [3:0]  wsel_oh = 4'h1 << wsel;
    wire        fec_busy = |(fec_vec & ~wsel_oh);

    assign s_axi_awready_o = ~aw_got_q;
    assign s_axi_wready_o  = ~w_got_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = ~rvalid_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;

    wire [32:0] rd_w = reg_word(s_axi_araddr_i);

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_got_q  <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= `TSOF_RESP_OK;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `TSOF_RESP_OK;
        end else begin
            if (s_axi_awvalid_i && !aw_got_q) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && !w_got_q) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_old[32] ? `TSOF_RESP_OK : `TSOF_RESP_ERR;
            end else if (bvalid_q && s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
            if (s_axi_arvalid_i && !rvalid_q) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_w[31:0];
                rresp_q  <= rd_w[32] ? `TSOF_RESP_OK : `TSOF_RESP_ERR;
            end else if (rvalid_q && s_axi_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ======================================================
    // per-stream pacing and configuration
    // ======================================================
    wire       can = ~out_valid_q | out_ready_i;
    wire [5:0] cc  = ctrl_q[cur_q];
    wire [1:0] cpad = cc[`TSOF_CTRL_PAD_HI:`TSOF_CTRL_PAD_LO];
    wire       use_src = cc[`TSOF_CTRL_CONN] & src_avail_i[cur_q];
    wire       slot_go = (st_q == ST_SLOT) & (cpad != `TSOF_PAD_OFF)
                         & can;
    wire       src_last = (st_q == ST_SRC) & src_valid_i & can
                          & (bc_q == `TSOF_PKT_LAST);
    wire       nul_last = (st_q == ST_NUL) & can
                          & (bc_q == `TSOF_PKT_LAST);
    wire       dg_end = (src_last | nul_last)
                        & (slot_q == `TSOF_SLOT_LAST);
    // source ahead of manual rate: drop one
    wire       drop_go = dg_end & (cpad == `TSOF_PAD_MAN)
                         & use_src & (cred_q[cur_q] == 4'h0);
    reg  [3:0] elig;
    reg  [1:0] pick;
    reg        pick_ok;
    integer    i;
    integer    k;

    always @* begin
        elig = 4'h0;
        pick = rr_q;
        pick_ok = 1'b0;
        for (k = 0; k < NUM_STREAMS; k = k + 1) begin
            if (ctrl_q[k][`TSOF_CTRL_EN]) begin
                // no padding waits for source data
                if (ctrl_q[k][4:3] == `TSOF_PAD_OFF)
                    elig[k] = ctrl_q[k][`TSOF_CTRL_CONN] & src_avail_i[k];
                else
                    elig[k] = (cred_q[k] >= `TSOF_CRED_NEED);
            end
        end
        for (k = NUM_STREAMS; k >= 1; k = k - 1) begin
            if (elig[rr_q + k[1:0]]) begin
                pick = rr_q + k[1:0];
                pick_ok = 1'b1;
            end
        end
    end

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (i = 0; i < NUM_STREAMS; i = i + 1) begin
                ctrl_q[i] <= `TSOF_RST_CTRL;
                port_q[i] <= `TSOF_RST_PORT;
                addr_q[i] <= `TSOF_RST_ADDR;
                rate_q[i] <= `TSOF_RST_RATE;
                per_q[i]  <= AUTO_INIT;
                gap_q[i]  <= 32'h0000_0000;
                tmr_q[i]  <= 32'h0000_0000;
                cred_q[i] <= 4'h0;
                seq_q[i]  <= 16'h0000;
            end
            rej_q     <= 4'h0;
            avail_d_q <= 4'h0;
        end else begin
            avail_d_q <= src_avail_i;
            for (i = 0; i < NUM_STREAMS; i = i + 1) begin
                // track shortest source gap, reset on change
                gap_q[i] <= gap_q[i] + 32'h0000_0001;
                if (src_cfg_chg_i[i]) begin
                    per_q[i] <= AUTO_INIT;
                    gap_q[i] <= 32'h0000_0000;
                end else if (src_avail_i[i] && !avail_d_q[i]) begin
                    gap_q[i] <= 32'h0000_0000;
                    if (gap_q[i] < per_q[i] && gap_q[i] != 32'h0)
                        per_q[i] <= gap_q[i];
                end
                // manual slots tick regardless of sources
                if (!ctrl_q[i][`TSOF_CTRL_EN] ||
                    ctrl_q[i][4:3] == `TSOF_PAD_OFF) begin
                    tmr_q[i]  <= 32'h0000_0000;
                    cred_q[i] <= 4'h0;
                end else begin
                    if (tmr_q[i] + 32'h0000_0001 >=
                        ((ctrl_q[i][4:3] == `TSOF_PAD_MAN) ?
                         rate_q[i] : per_q[i]))
                        tmr_q[i] <= 32'h0000_0000;
                    else
                        tmr_q[i] <= tmr_q[i] + 32'h0000_0001;
                    cred_q[i] <= cred_q[i]
                        + {3'h0, (tmr_q[i] == 32'h0 &&
                                  cred_q[i] != 4'hF)}
                        // no wrap below zero if padding turns on mid-run
                        - {3'h0, (slot_go && cur_q == i[1:0] &&
                                  cred_q[i] != 4'h0)};
                end
                // sequence steps once per rtp datagram
                if (st_q == ST_IDLE && pick_ok && pick == i[1:0] &&
                    rtp_eff(ctrl_q[i]))
                    seq_q[i] <= seq_q[i] + 16'h0001;
            end
            if (wstr) begin
                case (awaddr_q[3:2])
                    `TSOF_OFS_CTRL: begin
                        // fec refused while another owns it
                        ctrl_q[wsel] <= {wval[5:3],
                                         wval[2] & ~fec_busy, wval[1:0]};
                    end
                    `TSOF_OFS_PORT: begin
                        if (wval[15:0] != 16'h0000)
                            port_q[wsel] <= wval[15:0];
                    end
                    `TSOF_OFS_ADDR: begin
                        if (wval[31:24] == `TSOF_LOOP_NET) begin
                            rej_q[wsel] <= 1'b1;
                        end else begin
                            rej_q[wsel]  <= 1'b0;
                            addr_q[wsel] <= wval;
                        end
                    end
                    default: begin
                        if (wval != 32'h0000_0000)
                            rate_q[wsel] <= wval;
                    end
                endcase
            end
        end
    end

    // ======================================================
    // datagram sequencer and byte output
    // ======================================================
    // only rtp header, source and null packet bytes leave; no control packets exist
    reg [7:0]   nb;
    wire [12:0] null_pid = `TSOF_NULL_PID;
    always @* begin
        case (st_q)
            ST_HDR: begin
                case (bc_q[3:0])
                    4'h0:    nb = `TSOF_RTP_B0;
                    4'h1:    nb = `TSOF_RTP_PT;
                    4'h2:    nb = seq_q[cur_q][15:8];
                    4'h3:    nb = seq_q[cur_q][7:0];
                    4'h4:    nb = stamp_q[31:24];
                    4'h5:    nb = stamp_q[23:16];
                    4'h6:    nb = stamp_q[15:8];
                    4'h7:    nb = stamp_q[7:0];
                    4'h8:    nb = SSRC[31:24];
                    4'h9:    nb = SSRC[23:16];
                    4'hA:    nb = SSRC[15:8];
                    default: nb = SSRC[7:0];
                endcase
            end
            ST_NUL: begin
                // null packet header with pid 0x1fff
                case (bc_q)
                    8'h00:   nb = `TSOF_SYNC;
                    8'h01:   nb = {3'h0, null_pid[12:8]};
                    8'h02:   nb = null_pid[7:0];
                    8'h03:   nb = `TSOF_NULL_B3;
                    default: nb = `TSOF_FILL;
                endcase
            end
            default: nb = src_data_i;
        endcase
    end

    wire emit = can & ((st_q == ST_HDR) | (st_q == ST_NUL) |
                       ((st_q == ST_SRC) & src_valid_i));

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q        <= ST_IDLE;
            cur_q       <= 2'h0;
            rr_q        <= 2'h0;
            slot_q      <= 3'h0;
            bc_q        <= 8'h00;
            first_q     <= 1'b0;
            stamp_q     <= 32'h0000_0000;
            ts_q        <= 32'h0000_0000;
            drops_q     <= 32'h0000_0000;
            dg_start_q  <= 1'b0;
            dg_port_q   <= 16'h0000;
            dg_addr_q   <= 32'h0000_0000;
            dg_rtp_q    <= 1'b0;
            dg_fec_q    <= 1'b0;
            out_data_q  <= 8'h00;
            out_valid_q <= 1'b0;
            out_sop_q   <= 1'b0;
            out_eop_q   <= 1'b0;
        end else begin
            ts_q       <= ts_q + 32'h0000_0001;
            dg_start_q <= 1'b0;
            if (can)
                out_valid_q <= 1'b0;
            if (emit) begin
                out_valid_q <= 1'b1;
                out_data_q  <= nb;
                out_sop_q   <= first_q;
                out_eop_q   <= dg_end;
                first_q     <= 1'b0;
            end
            case (st_q)
                ST_IDLE: begin
                    if (pick_ok) begin
                        cur_q      <= pick;
                        rr_q       <= pick;
                        slot_q     <= 3'h0;
                        bc_q       <= 8'h00;
                        first_q    <= 1'b1;
                        stamp_q    <= ts_q;
                        dg_start_q <= 1'b1;
                        dg_rtp_q   <= rtp_eff(ctrl_q[pick]);
                        dg_fec_q   <= ctrl_q[pick][`TSOF_CTRL_FEC];
                        dg_addr_q  <= addr_q[pick];
                        dg_port_q  <= port_eff(port_q[pick],
                                               rtp_eff(ctrl_q[pick]));
                        st_q <= rtp_eff(ctrl_q[pick]) ? ST_HDR : ST_SLOT;
                    end
                end
                ST_HDR: begin
                    if (can) begin
                        bc_q <= bc_q + 8'h01;
                        if (bc_q == `TSOF_RTP_LAST) begin
                            bc_q <= 8'h00;
                            st_q <= ST_SLOT;
                        end
                    end
                end
                ST_SLOT: begin
                    bc_q <= 8'h00;
                    if (use_src)
                        st_q <= ST_SRC;
                    else if (slot_go)
                        st_q <= ST_NUL;
                end
                ST_SRC, ST_NUL: begin
                    if (emit) begin
                        bc_q <= bc_q + 8'h01;
                        if (bc_q == `TSOF_PKT_LAST) begin
                            slot_q <= slot_q + 3'h1;
                            st_q <= (slot_q == `TSOF_SLOT_LAST) ?
                                    (drop_go ? ST_DROP : ST_IDLE) :
                                    ST_SLOT;
                            bc_q <= 8'h00;
                        end
                    end
                end
                ST_DROP: begin
                    if (src_valid_i) begin
                        bc_q <= bc_q + 8'h01;
                        if (bc_q == `TSOF_PKT_LAST) begin
                            drops_q <= drops_q + 32'h0000_0001;
                            st_q <= ST_IDLE;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    assign src_sel_o   = cur_q;
    assign src_ready_o = ((st_q == ST_SRC) & can) | (st_q == ST_DROP);
    assign dg_start_o  = dg_start_q;
    assign dg_stream_o = cur_q;
    assign dg_port_o   = dg_port_q;
    assign dg_addr_o   = dg_addr_q;
    assign dg_bcast_o  = (dg_addr_q == `TSOF_BCAST_IP);
    assign dg_rtp_o    = dg_rtp_q;
    assign dg_fec_o    = dg_fec_q;
    assign out_data_o  = out_data_q;
    assign out_valid_o = out_valid_q;
    assign out_sop_o   = out_sop_q;
    assign out_eop_o   = out_eop_q;
endmodule

/* File: verif/tsof_framer_asserts.sv */
`timescale 1ns/1ps
module tsof_chk (
    input wire logic        core_clk_i,  // clock
    input wire logic        arst_n_i,    // reset, low
    input wire logic [7:0]  out_data_o,  // payload byte
    input wire logic        out_valid_o, // byte valid
    input wire logic        out_sop_o,   // first byte
    input wire logic        out_eop_o,   // last byte
    input wire logic        out_ready_i, // sink ready
    input wire logic        dg_start_o,  // datagram pick
    input wire logic [15:0] dg_port_o,   // udp port
    input wire logic [31:0] dg_addr_o,   // ip address
    input wire logic        dg_bcast_o,  // broadcast mac
    input wire logic        dg_rtp_o,    // rtp present
    input wire logic        dg_fec_o     // fec on
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (!arst_n_i);
// ======
// byte index inside the datagram being sent
logic [10:0] n_q;
always_ff @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i) n_q <= 11'h000;
    else if (out_valid_o && out_ready_i) n_q <= out_eop_o ? 11'h000 : n_q + 1'b1;
sequence s_stall; out_valid_o && !out_ready_i; endsequence
sequence s_held; out_valid_o && $stable(out_data_o); endsequence
property p_len; out_valid_o && out_ready_i && out_eop_o
    |-> n_q == (dg_rtp_o ? 11'h52F : 11'h523); endproperty
a_len: assert property (p_len) else $error("wrong datagram size");
property p_hold; s_stall |=> s_held; endproperty
a_hold: assert property (p_hold) else $error("byte changed in stall");
property p_first; out_valid_o && out_sop_o
    |-> n_q == 11'h000 && out_data_o == (dg_rtp_o ? 8'h80 : 8'h47); endproperty
a_first: assert property (p_first) else $error("bad first byte");
property p_even; dg_rtp_o |-> !dg_port_o[0]; endproperty
a_even: assert property (p_even) else $error("odd port with rtp");
property p_port; dg_start_o |-> dg_port_o != 16'h0000; endproperty
a_port: assert property (p_port) else $error("port zero");
property p_loop; dg_start_o |-> dg_addr_o[31:24] != 8'h7F; endproperty
a_loop: assert property (p_loop) else $error("loopback sent");
property p_bc; dg_start_o && dg_addr_o == 32'hFFFF_FFFF |-> dg_bcast_o; endproperty
a_bc: assert property (p_bc) else $error("no broadcast mac");
property p_fec; dg_fec_o |-> dg_rtp_o; endproperty
a_fec: assert property (p_fec) else $error("fec without rtp");
endmodule
bind tsof_framer tsof_chk u_chk (.*);

/* File: verif/tsof_sink.sv */
`timescale 1ns/1ps
// ======
// network side: takes bytes, stalls every other cycle when slow
module tsof_sink (
    input  wire logic        core_clk_i, // clock
    input  wire logic        arst_n_i,   // reset, low
    input  wire logic [7:0]  dat_i,      // payload byte
    input  wire logic        vld_i,      // byte valid
    input  wire logic        sop_i,      // first byte
    input  wire logic        eop_i,      // last byte
    input  wire logic        slow_i,     // stall mode
    output wire logic        rdy_o,      // ready
    output logic      [15:0] len_o,      // last datagram size
    output logic      [15:0] cnt_o,      // datagrams seen
    output logic      [7:0]  hdr_o [16]  // first bytes kept
);
logic        ph_q;
logic [15:0] idx;
assign rdy_o = !slow_i || ph_q;
assign idx = sop_i ? 16'h0000 : len_o;
always_ff @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i) begin
        ph_q <= 1'b0;
        len_o <= 16'h0000;
        cnt_o <= 16'h0000;
    end else begin
        ph_q <= !ph_q;
        if (vld_i && rdy_o) begin
            if (idx < 16) hdr_o[idx[3:0]] <= dat_i;
            len_o <= idx + 1'b1;
            if (eop_i) cnt_o <= cnt_o + 1'b1;
        end
    end
endmodule

/* File: verif/tb_ts_over_ip_output_framer.sv */
`timescale 1ns/1ps
module tb_ts_over_ip_output_framer;
logic core_clk_i = 0, arst_n_i = 0, slow = 0, out_ready_i;
logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, src_data_i = 8'h47;
logic [31:0] s_axi_wdata_i = 0;
logic [3:0] s_axi_wstrb_i = 4'hF, src_avail_i = 0, src_cfg_chg_i = 0;
logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, src_valid_i = 1;
wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
wire s_axi_rvalid_o, src_ready_o, dg_start_o, dg_bcast_o, dg_rtp_o;
wire dg_fec_o, out_valid_o, out_sop_o, out_eop_o;
wire [1:0] s_axi_bresp_o, s_axi_rresp_o, src_sel_o, dg_stream_o;
wire [15:0] dg_port_o, len, cnt;
wire [31:0] s_axi_rdata_o, dg_addr_o;
wire [7:0] out_data_o, hdr [16];
int failures = 0, check_count = 0;
logic [31:0] d, s;
logic [1:0] r;
tsof_framer #(.AUTO_INIT(32'h0000_0010)) DUT (.*);
tsof_sink u_sink (.core_clk_i, .arst_n_i, .dat_i(out_data_o),
    .vld_i(out_valid_o), .sop_i(out_sop_o), .eop_i(out_eop_o),
    .slow_i(slow), .rdy_o(out_ready_i), .len_o(len), .cnt_o(cnt), .hdr_o(hdr));
initial forever #20 core_clk_i = ~core_clk_i;
// ======
task chk(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
        failures++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a; s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1; s_axi_wvalid_i <= 1; s_axi_bready_i <= 1;
    do begin
        @(posedge core_clk_i);
        if (s_axi_awready_o) s_axi_awvalid_i <= 0;
        if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end while (!s_axi_bvalid_o);
    s_axi_bready_i <= 0;
endtask
task rd(input logic [7:0] a);
    @(posedge core_clk_i);
    s_axi_araddr_i <= a; s_axi_arvalid_i <= 1; s_axi_rready_i <= 1;
    do begin
        @(posedge core_clk_i);
        if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end while (!s_axi_rvalid_o);
    d = s_axi_rdata_o; r = s_axi_rresp_o; s_axi_rready_i <= 0;
endtask
// waits for the next complete datagram at the sink
task wdg;
    logic [15:0] c;
    c = cnt;
    repeat (6000) begin
        @(posedge core_clk_i);
        if (cnt != c) return;
    end
    failures++;
endtask
task test_done;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
// ======
task sc_null; // manual padding, no source: all nulls
    rd(8'h04); chk(d, 32'h0000_0400);
    rd(8'h48); chk(r, 2'h2);
    wr(8'h04, 32'h0000_0000); rd(8'h04); chk(d, 32'h0000_0400);
    wr(8'h0C, 32'h0000_012C); wr(8'h00, 32'h0000_0011); wdg;
    chk(len, 16'h0524);
    chk({hdr[0], hdr[1], hdr[2], hdr[3]}, 32'h471F_FF10);
endtask
task sc_rtp;
    wr(8'h00, 32'h0000_0013); wr(8'h04, 32'h0000_0401);
    rd(8'h04); chk(d, 32'h0000_0402);
    wdg; wdg;
    s = {hdr[2], hdr[3]}; wdg;
    chk(len, 16'h0530);
    chk({hdr[0], hdr[1]}, 16'h8021);
    chk({hdr[2], hdr[3]}, s[15:0] + 16'h0001);
    chk({hdr[12], hdr[13], hdr[14], hdr[15]}, 32'h471F_FF10);
endtask
task sc_fec; // broadcast, loopback refusal, fec ownership, stalls
    wr(8'h08, 32'hFFFF_FFFF); wr(8'h08, 32'h7F00_0001);
    rd(8'h08); chk(d, 32'hFFFF_FFFF);
    rd(8'h40); chk(d & 32'h1, 32'h1);
    wr(8'h00, 32'h0000_0015); wr(8'h10, 32'h0000_0004);
    rd(8'h10); chk(d, 32'h0000_0000);
    slow <= 1; wdg; wdg;
    chk({dg_bcast_o, dg_fec_o, dg_rtp_o, dg_stream_o, dg_port_o},
        {3'h7, 2'h0, 16'h0402});
endtask
task sc_src; // connected source: overrun drops, auto, then no padding
    slow <= 0; src_avail_i <= 4'h1;
    wr(8'h0C, 32'h0000_0578); wr(8'h00, 32'h0000_0031);
    repeat (14000) @(posedge core_clk_i);
    rd(8'h44); chk(d == 32'h0, 1'b0);
    wr(8'h00, 32'h0000_0029); wdg; wdg; chk(len, 16'h0524);
    wr(8'h00, 32'h0000_0021); wdg; wdg; chk(hdr[1], 8'h47);
endtask
task sc_dis; // nothing at all once disabled, even padding
    wr(8'h00, 32'h0000_0010); slow <= 0;
    repeat (3000) @(posedge core_clk_i);
    s = cnt;
    repeat (5000) @(posedge core_clk_i);
    chk(cnt, s);
endtask
initial begin
    repeat (6) @(posedge core_clk_i);
    arst_n_i <= 1;
    sc_null; sc_rtp; sc_fec; sc_src; sc_dis;
    test_done;
end
initial begin
    #3_000_000;
    failures++;
    test_done;
end
endmodule
